// ### rtl/host_addr_defs.svh
// constants for the host address acquisition block
`ifndef HOST_ADDR_DEFS_SVH
`define HOST_ADDR_DEFS_SVH
`define HA_CMD_MAX 48
`define HA_CMD_AW 6
`define HA_ADDR_MAX 16
`define HA_MAC_BYTES 6
`define HA_PROBE_TRIES 3'd5
`define HA_MAC_ADDR_OFFSET 8'h01
`define HA_CLK_PERIOD_NS 8
`define HA_MS_NS 1000000
`define HA_IDLE_MIN_MS 16'h03e8
`define HA_IDLE_MAX_MS 16'h1388
`define HA_TIMEOUT_DFLT_MS 16'h0fa0
`define HA_SYNC_PKT_TICKS 16'h0005
`define HA_SEL_PROBE 2'h0
`define HA_SEL_FIRST 2'h1
`define HA_SEL_SECOND 2'h2
`endif

// ### rtl/host_addr_pkg.sv
// types shared by the host address acquisition block
package host_addr_pkg;
    typedef enum logic {MODE_HOST, MODE_MAC} addr_mode_t;
    typedef enum {ST_INIT, ST_CHECK, ST_BOOT, ST_SEND, ST_WAIT, ST_LEARN,
        ST_HELD, ST_MAC} acq_state_t;
    typedef struct packed {
        logic unsync_en;
        logic [15:0] backoff_tick_us;
        logic [15:0] wake_slot;
        logic [15:0] sleep_ratio;
        logic [15:0] idle_ms;
        logic [15:0] comp_unit;
        logic [15:0] sync_dur;
        logic [15:0] beacon_dur;
        logic [15:0] down_ms;
        logic [15:0] up_ms;
    } sleep_cfg_t;
    typedef struct packed {
        logic [31:0] listen_us;
        logic [15:0] sleep_idle_ms;
        logic [15:0] cal_ms;
        logic [23:0] hop_extra;
        logic [15:0] sync_ticks;
        logic [15:0] sync_repeats;
        logic [15:0] beacon_ticks;
        logic beacon_ok;
        logic [15:0] down_ms;
        logic [15:0] up_ms;
    } sleep_par_t;
endpackage

// ### rtl/cmd_store.sv
// byte store for one configured command, registered read
`timescale 1ns/1ps
`default_nettype none
module cmd_store #(
    parameter int DEPTH = 48,
    parameter int AW = 6
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    generate
        if (DEPTH < 1 || DEPTH > (1 << AW))
        begin : g_bad
            $error("cmd_store depth does not fit address width");
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (wr_en && wr_addr < AW'(DEPTH))
            mem[wr_addr] <= wr_data;
    end

    always_ff @(posedge sys_clk)
    begin
        rd_data <= (rd_addr < AW'(DEPTH)) ? mem[rd_addr] : 8'h00;
    end
endmodule // cmd_store
`default_nettype wire

// ### rtl/host_address_acquisition.sv
// address mode selection, host address probing and canned commands
//
// Operation
// RULE1: probe at most 48 bytes, sent verbatim
// RULE2: host reply framed per parser configuration
// RULE3: no probe configured means MAC mode; code also needs a first canned command, else it learns
// RULE4: probe at boot, capture address, five tries
// RULE5: boot delay, reply timeout, resend on expiry
// RULE6: address length one to sixteen bytes
// RULE7: captured address frozen until reset
// RULE8: both empty: learn from first frame
// RULE9: MAC mode wraps payload in sync+MAC head
// RULE10: head sync is first canned byte zero
// RULE11: MAC mode offsets both equal one
// RULE12: two canned commands, root sends substitute
// RULE13: listen slice counted in backoff ticks
// RULE14: idle timeout or calibration, one-five seconds
// RULE15: idle timeout plus hops times compensation
// RULE16: sync burst duration, five ticks per packet
// RULE17: beacon duration against ratio times slot
// RULE18: delivery timeouts, four second default
// RULE19: wildcard address matches every node
`timescale 1ns/1ps
`default_nettype none
`include "host_addr_defs.svh"
module host_address_acquisition #(
    parameter int MS_CYCLES = `HA_MS_NS / `HA_CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cfg_wr_en,
    input wire logic [1:0] cfg_wr_sel,
    input wire logic [5:0] cfg_wr_idx,
    input wire logic [7:0] cfg_wr_data,
    input wire logic [5:0] probe_len,
    input wire logic [5:0] first_canned_len,
    input wire logic [5:0] second_canned_len,
    input wire logic [4:0] addr_len,
    input wire logic [7:0] bcast_wild,
    input wire logic [7:0] mcast_wild,
    input wire logic [47:0] mac_addr,
    input wire logic [7:0] cfg_dl_offset,
    input wire logic [7:0] cfg_ul_offset,
    input wire logic [15:0] boot_delay_ms,
    input wire logic [15:0] reply_timeout_ms,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic host_frame_valid,
    input wire logic [127:0] host_frame_addr,
    input wire logic dst_valid,
    input wire logic [127:0] dst_addr,
    output logic dst_match,
    output logic dst_wild,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    output logic cmd_ready,
    output logic canned_hit,
    output logic canned_sel,
    input wire logic is_root,
    input wire logic [7:0] hop_count,
    input wire host_addr_pkg::sleep_cfg_t sleep_cfg,
    output host_addr_pkg::sleep_par_t sleep_par,
    output host_addr_pkg::addr_mode_t addr_mode,
    output logic [127:0] node_addr,
    output logic addr_valid,
    output logic downlink_enable,
    output logic probing,
    output logic gave_up,
    output logic [7:0] head_sync,
    output logic [7:0] dl_offset,
    output logic [7:0] ul_offset
);
    // ----
    // declarations
    // ----
    host_addr_pkg::acq_state_t state;
    host_addr_pkg::acq_state_t last_state;
    logic [5:0] rd_addr [3];
    logic [7:0] rd_data [3];
    logic [5:0] probe_eff;
    logic [5:0] first_eff;
    logic [5:0] second_eff;
    logic [4:0] addr_eff;
    logic [15:0] byte_on;
    logic [15:0] bc_eq;
    logic [15:0] mc_eq;
    logic [127:0] addr_mask;
    logic [127:0] mac_pad;
    logic [16:0] ms_div;
    logic [15:0] ms_cnt;
    logic [2:0] tries;
    logic [5:0] tx_idx;
    logic tx_hold;
    logic send_done;
    logic capture;
    logic mac_pick;
    logic [5:0] cmp_idx;
    logic eq_first;
    logic eq_second;
    logic accept;
    logic next_eq_first;
    logic next_eq_second;
    logic [31:0] sleep_slice;
    logic [15:0] idle_clamp;

    generate
        if (MS_CYCLES < 1 || MS_CYCLES > 131071)
        begin : g_bad_ms
            $error("MS_CYCLES out of range");
        end
    endgenerate

    // ----
    // command stores: probe, first and second canned command
    // ----
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_store
            cmd_store #(.DEPTH(`HA_CMD_MAX), .AW(`HA_CMD_AW)) u_store (
                .sys_clk(sys_clk),
                .wr_en(cfg_wr_en && cfg_wr_sel == 2'(gi)),
                .wr_addr(cfg_wr_idx),
                .wr_data(cfg_wr_data),
                .rd_addr(rd_addr[gi]),
                .rd_data(rd_data[gi])
            );
        end
    endgenerate

    assign rd_addr[0] = tx_idx;
    assign rd_addr[1] = cmp_idx;
    assign rd_addr[2] = cmp_idx;

    // length clamps
    assign probe_eff = (probe_len > 6'(`HA_CMD_MAX)) ? 6'(`HA_CMD_MAX)
        : probe_len; // [RULE1]
    assign first_eff = (first_canned_len > 6'(`HA_CMD_MAX))
        ? 6'(`HA_CMD_MAX) : first_canned_len; // [RULE12]
    assign second_eff = (second_canned_len > 6'(`HA_CMD_MAX))
        ? 6'(`HA_CMD_MAX) : second_canned_len; // [RULE12]
    assign addr_eff = (addr_len == 5'h00) ? 5'h01
        : (addr_len > 5'(`HA_ADDR_MAX)) ? 5'(`HA_ADDR_MAX)
        : addr_len; // [RULE6]

    // ----
    // per address byte masks and wildcard compares
    // ----
    generate
        for (gi = 0; gi < `HA_ADDR_MAX; gi++)
        begin : g_byte
            assign byte_on[gi] = 5'(gi) < addr_eff; // [RULE6]
            assign addr_mask[gi*8 +: 8] = {8{byte_on[gi]}};
            assign bc_eq[gi] = !byte_on[gi]
                || dst_addr[gi*8 +: 8] == bcast_wild; // [RULE19]
            assign mc_eq[gi] = !byte_on[gi]
                || dst_addr[gi*8 +: 8] == mcast_wild; // [RULE19]
            if (gi < `HA_MAC_BYTES)
            begin : g_mac
                assign mac_pad[gi*8 +: 8] = mac_addr[gi*8 +: 8];
            end
            else
            begin : g_pad
                assign mac_pad[gi*8 +: 8] = 8'h00;
            end
        end
    endgenerate

    // ----
    // millisecond timer, restarted on every state change
    // ----
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_state <= host_addr_pkg::ST_INIT;
            ms_div <= 17'h00000;
            ms_cnt <= 16'h0000;
        end
        else
        begin
            last_state <= state;
            if (state != last_state)
            begin
                ms_div <= 17'h00000;
                ms_cnt <= 16'h0000;
            end
            else if (ms_div == 17'(MS_CYCLES - 1))
            begin
                ms_div <= 17'h00000;
                if (ms_cnt != 16'hffff)
                    ms_cnt <= ms_cnt + 16'h0001;
            end
            else
                ms_div <= ms_div + 17'h00001;
        end
    end

    // ----
    // acquisition state machine
    // ----
    assign send_done = state == host_addr_pkg::ST_SEND && !tx_valid
        && !tx_hold && tx_idx == probe_eff;
    assign capture = host_frame_valid && (state == host_addr_pkg::ST_WAIT
        || state == host_addr_pkg::ST_LEARN); // [RULE4] [RULE8]
    assign mac_pick = state == host_addr_pkg::ST_CHECK
        && probe_eff == 6'h00 && first_eff != 6'h00;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= host_addr_pkg::ST_INIT;
            tries <= 3'h0;
            gave_up <= 1'b0;
        end
        else
        begin
            unique case (state)
                host_addr_pkg::ST_INIT:
                    state <= host_addr_pkg::ST_CHECK;
                host_addr_pkg::ST_CHECK:
                    if (probe_eff != 6'h00)
                        state <= host_addr_pkg::ST_BOOT; // [RULE3]
                    else if (first_eff == 6'h00)
                        state <= host_addr_pkg::ST_LEARN; // [RULE8]
                    else
                        state <= host_addr_pkg::ST_MAC; // [RULE3]
                host_addr_pkg::ST_BOOT:
                    if (ms_cnt >= boot_delay_ms)
                        state <= host_addr_pkg::ST_SEND; // [RULE5]
                host_addr_pkg::ST_SEND:
                    if (send_done)
                        state <= host_addr_pkg::ST_WAIT;
                host_addr_pkg::ST_WAIT:
                    if (host_frame_valid)
                        state <= host_addr_pkg::ST_HELD; // [RULE4]
                    else if (ms_cnt >= reply_timeout_ms)
                    begin
                        tries <= tries + 3'h1;
                        if (tries + 3'h1 == `HA_PROBE_TRIES)
                        begin
                            state <= host_addr_pkg::ST_LEARN; // [RULE4]
                            gave_up <= 1'b1;
                        end
                        else
                            state <= host_addr_pkg::ST_SEND; // [RULE5]
                    end
                host_addr_pkg::ST_LEARN:
                    if (host_frame_valid)
                        state <= host_addr_pkg::ST_HELD; // [RULE8]
                host_addr_pkg::ST_HELD,
                host_addr_pkg::ST_MAC:
                    state <= state; // [RULE7]
            endcase
        end
    end

    // ----
    // probe transmitter, bytes exactly as stored
    // ----
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_idx <= 6'h00;
            tx_hold <= 1'b1;
        end
        else if (state != host_addr_pkg::ST_SEND)
        begin
            tx_idx <= 6'h00;
            tx_hold <= 1'b1;
        end
        else if (tx_valid && tx_ready)
        begin
            tx_valid <= 1'b0;
            tx_hold <= 1'b0;
        end
        else if (!tx_valid && !tx_hold && tx_idx < probe_eff)
        begin
            tx_data <= rd_data[0]; // [RULE1]
            tx_valid <= 1'b1;
            tx_idx <= tx_idx + 6'h01;
            tx_hold <= 1'b1;
        end
        else
            tx_hold <= 1'b0;
    end

    // ----
    // address selection and mode outputs
    // ----
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            node_addr <= 128'h0;
            addr_valid <= 1'b0;
            addr_mode <= host_addr_pkg::MODE_HOST;
            head_sync <= 8'h00;
            dl_offset <= 8'h00;
            ul_offset <= 8'h00;
            downlink_enable <= 1'b0;
            probing <= 1'b0;
        end
        else
        begin
            if (!addr_valid && capture)
            begin
                node_addr <= host_frame_addr & addr_mask; // [RULE4] [RULE6]
                addr_valid <= 1'b1;
            end
            else if (!addr_valid && mac_pick)
            begin
                node_addr <= mac_pad & addr_mask; // [RULE9]
                addr_valid <= 1'b1;
                addr_mode <= host_addr_pkg::MODE_MAC; // [RULE3]
                head_sync <= rd_data[1]; // [RULE10]
            end
            if (addr_mode == host_addr_pkg::MODE_MAC)
            begin
                dl_offset <= `HA_MAC_ADDR_OFFSET; // [RULE11]
                ul_offset <= `HA_MAC_ADDR_OFFSET; // [RULE11]
            end
            else
            begin
                dl_offset <= cfg_dl_offset;
                ul_offset <= cfg_ul_offset;
            end
            downlink_enable <= addr_valid; // [RULE8]
            probing <= state == host_addr_pkg::ST_BOOT
                || state == host_addr_pkg::ST_SEND
                || state == host_addr_pkg::ST_WAIT;
        end
    end

    // ----
    // destination address match
    // ----
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dst_match <= 1'b0;
            dst_wild <= 1'b0;
        end
        else
        begin
            dst_wild <= dst_valid && (&bc_eq || &mc_eq); // [RULE19]
            dst_match <= dst_valid && (&bc_eq || &mc_eq || (addr_valid
                && (dst_addr & addr_mask) == node_addr)); // [RULE19]
        end
    end

    // ----
    // canned broadcast command compare
    // ----
    assign accept = cmd_valid && cmd_ready;
    assign next_eq_first = eq_first && cmp_idx < first_eff
        && cmd_data == rd_data[1];
    assign next_eq_second = eq_second && cmp_idx < second_eff
        && cmd_data == rd_data[2];

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_idx <= 6'h00;
            eq_first <= 1'b1;
            eq_second <= 1'b1;
            cmd_ready <= 1'b1;
            canned_hit <= 1'b0;
            canned_sel <= 1'b0;
        end
        else
        begin
            cmd_ready <= !accept;
            canned_hit <= 1'b0;
            if (accept && cmd_last)
            begin
                cmp_idx <= 6'h00;
                eq_first <= 1'b1;
                eq_second <= 1'b1;
                canned_hit <= is_root && ((next_eq_first
                    && {1'b0, cmp_idx} + 7'h01 == {1'b0, first_eff})
                    || (next_eq_second
                    && {1'b0, cmp_idx} + 7'h01 == {1'b0, second_eff}));
                canned_sel <= !(next_eq_first
                    && {1'b0, cmp_idx} + 7'h01 == {1'b0, first_eff});
            end // [RULE12]
            else if (accept)
            begin
                if (cmp_idx != 6'h3f)
                    cmp_idx <= cmp_idx + 6'h01;
                eq_first <= next_eq_first;
                eq_second <= next_eq_second;
            end
        end
    end

    // ----
    // sleep and timeout parameters
    // ----
    assign sleep_slice = sleep_cfg.sleep_ratio * sleep_cfg.wake_slot;
    assign idle_clamp = (sleep_cfg.idle_ms < `HA_IDLE_MIN_MS)
        ? `HA_IDLE_MIN_MS : (sleep_cfg.idle_ms > `HA_IDLE_MAX_MS)
        ? `HA_IDLE_MAX_MS : sleep_cfg.idle_ms; // [RULE14]

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sleep_par <= '0;
        else
        begin
            sleep_par.listen_us <= sleep_cfg.wake_slot
                * sleep_cfg.backoff_tick_us; // [RULE13]
            sleep_par.sleep_idle_ms <= sleep_cfg.unsync_en
                ? idle_clamp : 16'h0000; // [RULE14]
            sleep_par.cal_ms <= idle_clamp; // [RULE14]
            sleep_par.hop_extra <= hop_count
                * sleep_cfg.comp_unit; // [RULE15]
            sleep_par.sync_ticks <= sleep_cfg.sync_dur; // [RULE16]
            sleep_par.sync_repeats <= sleep_cfg.sync_dur
                / `HA_SYNC_PKT_TICKS; // [RULE16]
            sleep_par.beacon_ticks <= sleep_cfg.beacon_dur; // [RULE17]
            sleep_par.beacon_ok <= {15'h0, sleep_cfg.beacon_dur, 1'b0}
                >= sleep_slice && {16'h0, sleep_cfg.beacon_dur}
                <= sleep_slice; // [RULE17]
            sleep_par.down_ms <= (sleep_cfg.down_ms == 16'h0000)
                ? `HA_TIMEOUT_DFLT_MS : sleep_cfg.down_ms; // [RULE18]
            sleep_par.up_ms <= (sleep_cfg.up_ms == 16'h0000)
                ? `HA_TIMEOUT_DFLT_MS : sleep_cfg.up_ms; // [RULE18]
        end
    end

    // ----
    // assertions
    // ----
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    chk_probe_bytes: assert property ( // [RULE1]
        tx_valid |-> tx_idx <= probe_eff && tx_idx != 6'h00)
        else $error("probe longer than configured");
    chk_mode_choice: assert property ( // [RULE3]
        state == host_addr_pkg::ST_CHECK && probe_eff != 6'h00
        |=> state == host_addr_pkg::ST_BOOT)
        else $error("probe configured but not used");
    chk_give_up_five: assert property ( // [RULE4]
        $rose(gave_up) |-> tries == `HA_PROBE_TRIES
        && state == host_addr_pkg::ST_LEARN)
        else $error("gave up after wrong try count");
    chk_boot_wait: assert property ( // [RULE5]
        state == host_addr_pkg::ST_BOOT && ms_cnt < boot_delay_ms
        |=> !tx_valid)
        else $error("probe sent before boot delay");
    chk_addr_frozen: assert property ( // [RULE7]
        addr_valid |=> addr_valid && $stable(node_addr))
        else $error("captured address changed");
    chk_relay_only: assert property ( // [RULE8]
        !addr_valid [*2] |-> !downlink_enable)
        else $error("downlink without address");
    chk_mac_offset: assert property ( // [RULE11]
        addr_mode == host_addr_pkg::MODE_MAC |=> dl_offset == 8'h01
        && ul_offset == 8'h01)
        else $error("mac mode offsets wrong");
    chk_canned_root: assert property ( // [RULE12]
        canned_hit |-> $past(is_root) && $past(accept && cmd_last))
        else $error("substitute without root end");
    chk_idle_range: assert property ( // [RULE14]
        sleep_par.cal_ms >= `HA_IDLE_MIN_MS
        || $past(!rst_n, 1) || $past(state == host_addr_pkg::ST_INIT))
        else $error("idle timeout out of range");
    cov_captured: cover property (
        state == host_addr_pkg::ST_WAIT ##1 state == host_addr_pkg::ST_HELD);
    cov_gave_up: cover property ($rose(gave_up));
    cov_canned: cover property (canned_hit);
    cov_mac: cover property (addr_mode == host_addr_pkg::MODE_MAC);
endmodule // host_address_acquisition
`default_nettype wire

// ### dv/host_probe_model.sv
// behavioural host device that answers the address probe
`timescale 1ns/1ps
`default_nettype none
module host_probe_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic [5:0] probe_len,
    input wire logic [3:0] answer_on,
    input wire logic frame_req,
    input wire logic [127:0] reply_addr,
    output logic tx_ready,
    output logic host_frame_valid,
    output logic [127:0] host_frame_addr
);
    // ----
    // probe capture and reply
    // ----
    logic [7:0] got [$];
    int nbytes = 0;
    int nprobe = 0;
    int due = 0;
    initial
    begin
        tx_ready = 1'b0;
        host_frame_valid = 1'b0;
        host_frame_addr = '0;
    end
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            got.delete();
            nbytes = 0;
            nprobe = 0;
            due = 0;
        end
        else if (tx_valid && tx_ready)
        begin
            got.push_back(tx_data);
            nbytes++;
            if (nbytes == int'(probe_len))
            begin
                nbytes = 0;
                nprobe++;
                if (nprobe == int'(answer_on))
                    due = 3;
            end
        end
        if (frame_req)
            due = 1;
        tx_ready <= 1'($urandom % 2);
        host_frame_valid <= (due == 1);
        host_frame_addr <= (due == 1) ? reply_addr : ~host_frame_addr;
        if (due > 0)
            due--;
    end
endmodule // host_probe_model
`default_nettype wire

// ### dv/host_address_acquisition_tb.sv
// self-checking bench for host address acquisition
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD %0t value mismatch", $time); end end
module host_address_acquisition_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, cfg_wr_en = 1'b0, frame_req = 1'b0;
    logic [1:0] cfg_wr_sel = 2'h0;
    logic [5:0] cfg_wr_idx = 6'h00, probe_len = 6'h00;
    logic [5:0] first_canned_len = 6'h00, second_canned_len = 6'h00;
    logic [7:0] cfg_wr_data = 8'h00, bcast_wild = 8'h99, mcast_wild = 8'haa;
    logic [7:0] cfg_dl_offset = 8'h00, cfg_ul_offset = 8'h00, hop_count = 8'h00;
    logic [4:0] addr_len = 5'h00;
    logic [3:0] answer_on = 4'h0;
    logic [47:0] mac_addr = 48'h0;
    logic [15:0] boot_delay_ms = 16'h0002, reply_timeout_ms = 16'h0003;
    logic dst_valid = 1'b0, cmd_valid = 1'b0, cmd_last = 1'b0, is_root = 1'b0;
    logic [127:0] dst_addr = '0, reply_addr = '0, host_frame_addr, node_addr;
    logic [7:0] cmd_data = 8'h00, tx_data, head_sync, dl_offset, ul_offset;
    logic tx_ready, tx_valid, host_frame_valid, dst_match, dst_wild, cmd_ready;
    logic canned_hit, canned_sel, addr_valid, downlink_enable, gave_up, hit, hsel;
    logic probing;
    host_addr_pkg::sleep_cfg_t sleep_cfg = '0;
    host_addr_pkg::sleep_par_t sleep_par;
    host_addr_pkg::addr_mode_t addr_mode;
    logic [7:0] mem [3][48];
    int n_mismatch = 0;
    int check_count = 0;
    int ks [4] = '{1, 2, 1, 1};
    int kn [4] = '{2, 3, 1, 2};
    logic kr [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [1:0] ke [4] = '{2'b10, 2'b11, 2'b00, 2'b00};
    always #4 sys_clk = ~sys_clk;
    host_address_acquisition #(.MS_CYCLES(4)) dut (.*);
    host_probe_model host (.*);
    // ----
    // helpers
    // ----
    function automatic logic [127:0] msk(input logic [127:0] a, input int n);
        for (int i = n; i < 16; i++)
            a[i*8+:8] = 8'h00;
        return a;
    endfunction
    task automatic setup(input int pl, c1, c2, al, input logic [3:0] ans);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        for (int i = 0; i < 144; i++)
        begin
            @(posedge sys_clk);
            cfg_wr_en <= 1'b1;
            cfg_wr_sel <= 2'(i / 48);
            cfg_wr_idx <= 6'(i % 48);
            cfg_wr_data <= mem[i / 48][i % 48];
        end
        @(posedge sys_clk);
        cfg_wr_en <= 1'b0;
        probe_len <= 6'(pl);
        first_canned_len <= 6'(c1);
        second_canned_len <= 6'(c2);
        addr_len <= 5'(al);
        answer_on <= ans;
        cfg_dl_offset <= 8'($urandom);
        cfg_ul_offset <= 8'($urandom);
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask
    task automatic frame(input logic [127:0] ra);
        @(posedge sys_clk);
        reply_addr <= ra;
        frame_req <= 1'b1;
        @(posedge sys_clk);
        frame_req <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic dst(input logic [127:0] a, input logic m, w);
        @(posedge sys_clk);
        dst_valid <= 1'b1;
        dst_addr <= a;
        @(posedge sys_clk);
        dst_valid <= 1'b0;
        #1;
        `CHK({dst_match, dst_wild}, {m, w})
    endtask
    task automatic cmd(input int s, n, input logic r);
        hit = 1'b0;
        hsel = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            @(negedge sys_clk);
            while (cmd_ready !== 1'b1) @(negedge sys_clk);
            @(posedge sys_clk);
            is_root <= r;
            cmd_valid <= 1'b1;
            cmd_data <= mem[s][i];
            cmd_last <= (i == n - 1);
            @(posedge sys_clk);
            cmd_valid <= 1'b0;
        end
        repeat (2)
        begin
            #1;
            if (canned_hit === 1'b1)
                {hit, hsel} = {1'b1, canned_sel};
            @(posedge sys_clk);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    initial
    begin
        int k;
        logic [127:0] a;
        void'($urandom(32'h21cf));
        foreach (mem[s, i]) mem[s][i] = 8'($urandom);
        mac_addr = 48'({$urandom, $urandom});
        reply_addr = {$urandom, $urandom, $urandom, $urandom};
        a = msk(reply_addr, 5);
        setup(3, 2, 0, 5, 4'h2);
        for (k = 0; k < 3000 && addr_valid !== 1'b1; k++) @(posedge sys_clk);
        #1;
        `CHK(addr_mode, host_addr_pkg::MODE_HOST)
        `CHK(host.got.size(), 6)
        for (k = 0; k < 6; k++) `CHK(host.got[k], mem[0][k % 3])
        `CHK(node_addr, a)
        `CHK({dl_offset, ul_offset}, {cfg_dl_offset, cfg_ul_offset})
        frame(~reply_addr);
        `CHK(node_addr, a)
        dst(a, 1'b1, 1'b0);
        dst(reply_addr, 1'b0, 1'b0);
        dst({16{8'h99}}, 1'b1, 1'b1);
        dst({16{8'haa}}, 1'b1, 1'b1);
        setup(48, 2, 0, 0, 4'h0);
        for (k = 0; k < 8000 && gave_up !== 1'b1; k++) @(posedge sys_clk);
        #1;
        `CHK(host.got.size(), 240)
        for (k = 0; k < 240; k++) `CHK(host.got[k], mem[0][k % 48])
        `CHK(addr_valid, 1'b0)
        `CHK({gave_up, probing}, 2'b10)
        frame(~reply_addr);
        `CHK({addr_valid, node_addr}, {1'b1, msk(reply_addr, 1)})
        @(posedge sys_clk);
        hop_count <= 8'($urandom);
        sleep_cfg <= '{1'b0, 16'($urandom % 900), 16'($urandom % 900), 16'h0004,
            16'h0064, 16'($urandom), 16'($urandom), 16'h0020, 16'h0000, 16'h0010};
        setup(0, 2, 3, 8, 4'h0);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(addr_mode, host_addr_pkg::MODE_MAC)
        `CHK(node_addr, msk({80'h0, mac_addr}, 8))
        `CHK(head_sync, mem[1][0])
        `CHK({dl_offset, ul_offset}, 16'h0101)
        k = int'(sleep_cfg.wake_slot);
        `CHK(sleep_par.listen_us, 32'(k * int'(sleep_cfg.backoff_tick_us)))
        `CHK({sleep_par.sleep_idle_ms, sleep_par.cal_ms}, 32'h000003e8)
        `CHK(sleep_par.hop_extra, 24'(int'(hop_count) * int'(sleep_cfg.comp_unit)))
        `CHK(sleep_par.sync_repeats, 16'(sleep_cfg.sync_dur / 5))
        `CHK(sleep_par.beacon_ok, 1'(4 * k / 2 <= 32 && 32 <= 4 * k))
        `CHK({sleep_par.down_ms, sleep_par.up_ms}, 32'h0fa00010)
        for (k = 0; k < 4; k++)
        begin
            cmd(ks[k], kn[k], kr[k]);
            `CHK({hit, hsel}, ke[k])
        end
        setup(0, 0, 0, 20, 4'h0);
        repeat (10) @(posedge sys_clk);
        #1;
        `CHK({addr_valid, downlink_enable}, 2'b00)
        frame({$urandom, $urandom, $urandom, $urandom});
        `CHK({addr_valid, downlink_enable}, 2'b11)
        `CHK(node_addr, reply_addr)
        results();
    end
    initial
    begin
        #400000;
        n_mismatch++;
        results();
    end
endmodule // host_address_acquisition_tb
`default_nettype wire
